// >>> verilog/pli_map.vh
// constants for the port indicator block: modes, strap bits, 1 kHz divider
`ifndef PLI_MAP_VH
`define PLI_MAP_VH
`define PLI_MODE_USB 2'h0
`define PLI_MODE_OWN 2'h1
`define PLI_MODE_SPEED 2'h2
`define PLI_OWNER_NONE 2'h0
`define PLI_OWNER_A 2'h1
`define PLI_OWNER_B 2'h2
`define PLI_CLK_HZ 100000000
`define PLI_TOGGLE_HZ 1000
`define PLI_HALF_CYCLES (`PLI_CLK_HZ / (2 * `PLI_TOGGLE_HZ))
`define PLI_STRAP_DELAY 4'h3
`define PLI_SYNC_BIT0 0
`endif

// >>> verilog/pli_toggle.v
// shared 1 kHz square wave generator for the speed indication mode
`include "pli_map.vh"
module pli_toggle #(
   parameter HALF_CYCLES = `PLI_HALF_CYCLES
) (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire run_in,
   output reg wave_out
);
   reg [16:0] count;
   // equal halves; held low while stopped so restart is clean
   always @(posedge clk_sys_in) begin
      if (!rst_n_in || !run_in) begin
         count <= 17'h00000;
         wave_out <= 1'b0;
      end else if (count == HALF_CYCLES[16:0] - 17'h00001) begin
         count <= 17'h00000;
         wave_out <= ~wave_out;
      end else begin
         count <= count + 17'h00001;
      end
   end
endmodule

// >>> verilog/pli_port_led_indicator.v
// port indicator driver: eight pins, three modes, strap capture and polarity
// How it works
// - exactly one of three indicator modes; mode code 3 releases every pin instead
// - usb mode: first pin green, second amber
// - usb mode shows no host ownership
// - basic mode: owner A first, B second
// - disabled or unassigned port: both pins off
// - ownership shown during suspend or host loss
// - speed mode: low or full speed drives low
// - speed mode: high speed drives high
// - speed mode: owned, nothing attached, 1 kHz
// - speed mode: off means tri-stated pin
// - suspended connected port keeps speed level
// - hub suspend stops toggle, shows off
// - sample first pins after reset as straps
// - strap high active low, low active high
// - indicators disabled while reset asserted
`include "pli_map.vh"
module pli_port_led_indicator (
   input wire clk_sys_in,
   input wire rst_n_in,
   input wire [1:0] mode_in,
   input wire internal_default_in,
   input wire hub_suspend_in,
   input wire [3:0] port_enable_in,
   input wire [7:0] port_owner_in,
   input wire [3:0] port_attached_in,
   input wire [3:0] port_high_speed_in,
   input wire [3:0] usb_green_in,
   input wire [3:0] usb_amber_in,
   input wire [3:0] first_host_indicator_pins_in,
   output reg [3:0] first_host_indicator_pins_out,
   output reg [3:0] first_host_indicator_pins_oe_out,
   output reg [3:0] second_host_indicator_pins_out,
   output reg [3:0] second_host_indicator_pins_oe_out,
   output reg [3:0] strap_out,
   output reg strap_valid_out
);
   // three-stage sampler on the shared strap pins
   reg [3:0] sync1;
   reg [3:0] sync2;
   reg [3:0] sync3;
   reg [3:0] strap;
   reg [3:0] active_low;
   reg [3:0] strap_wait;
   reg strap_done;
   wire strap_agree;
   wire strap_due;
   // per-port results gathered from the generate slices
   wire wave;
   wire [3:0] next_a;
   wire [3:0] next_a_oe;
   wire [3:0] next_b;
   wire [3:0] next_b_oe;
   wire speed_mode;
   wire wave_run;
   genvar g;

   // pad readback is asynchronous to the hub clock, so it crosses in three stages
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
      end else begin
         sync1 <= first_host_indicator_pins_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // stages two and three must agree before a strap level is believed
   assign strap_agree = (sync2 == sync3);
   assign strap_due = (strap_wait == `PLI_STRAP_DELAY);

   // pins are undriven until capture so the straps read cleanly
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         strap_wait <= 4'h0;
         strap_done <= 1'b0;
         strap <= 4'h0;
         active_low <= 4'h0;
      end else if (!strap_done) begin
         if (strap_due) begin
            if (strap_agree) begin
               strap_done <= 1'b1;
               strap <= sync3;
               active_low <= sync3;
            end
         end else begin
            strap_wait <= strap_wait + 4'h1;
         end
      end
   end

   // speed mode is the only user of the shared wave
   assign speed_mode = (mode_in == `PLI_MODE_SPEED);
   // the wave is stopped and held low in hub suspend, so an idle owned port shows off
   assign wave_run = speed_mode && !hub_suspend_in;

   // one divider for all ports keeps every third colour in step
   pli_toggle u_toggle (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .run_in(wave_run),
      .wave_out(wave)
   );

   // one slice per downstream port; bit g of every 4-bit vector, and owner bits 2g+1:2g, is port g+1
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_port
         wire [1:0] owner;
         wire owned_a;
         wire owned_b;
         wire claimed;
         wire shows_speed;
         wire shows_wave;
         reg lit_a;
         reg lit_b;
         reg pin_a;
         reg pin_b;
         reg oe_a;
         reg oe_b;

         // owner code 3 names no host and so counts as unassigned
         assign owner = port_owner_in[2*g +: 2];
         assign owned_a = (owner == `PLI_OWNER_A);
         assign owned_b = (owner == `PLI_OWNER_B);
         // a disabled port is never claimed, whatever its owner field holds
         assign claimed = port_enable_in[g] && (owned_a || owned_b);
         // attached ports show speed; idle owned ports pulse unless suspended
         assign shows_speed = claimed && port_attached_in[g];
         assign shows_wave = claimed && !port_attached_in[g] && !hub_suspend_in;

         // lit is the logical on state before the strap polarity is applied
         always @* begin
            lit_a = 1'b0;
            lit_b = 1'b0;
            pin_a = 1'b0;
            pin_b = 1'b0;
            oe_a = 1'b0;
            oe_b = 1'b0;
            case (mode_in)
               `PLI_MODE_USB: begin
                  // ownership is deliberately ignored here
                  lit_a = usb_green_in[g];
                  lit_b = usb_amber_in[g];
                  pin_a = lit_a ^ active_low[g];
                  pin_b = lit_b ^ active_low[g];
                  oe_a = 1'b1;
                  oe_b = 1'b1;
               end
               `PLI_MODE_OWN: begin
                  // suspend and host loss never reach this decode
                  lit_a = claimed && owned_a;
                  lit_b = claimed && owned_b;
                  pin_a = lit_a ^ active_low[g];
                  pin_b = lit_b ^ active_low[g];
                  oe_a = 1'b1;
                  oe_b = 1'b1;
               end
               `PLI_MODE_SPEED: begin
                  // levels pick colours here, so the strap polarity is not used
                  if (shows_speed) begin
                     // the port logic holds the enumerated speed through suspend
                     pin_a = owned_a && port_high_speed_in[g];
                     pin_b = owned_b && port_high_speed_in[g];
                     oe_a = owned_a;
                     oe_b = owned_b;
                  end else if (shows_wave) begin
                     // nothing attached: pulse the owner's pin for the third colour
                     pin_a = owned_a && wave;
                     pin_b = owned_b && wave;
                     oe_a = owned_a;
                     oe_b = owned_b;
                  end
                  // the non-owner pin and every off pin keep oe low and float
               end
               default: begin
                  // code 3 is no mode at all: every pin is released
                  oe_a = 1'b0;
                  oe_b = 1'b0;
               end
            endcase
         end

         // gather the slice into the shared next-state vectors
         assign next_a[g] = pin_a;
         assign next_a_oe[g] = oe_a;
         assign next_b[g] = pin_b;
         assign next_b_oe[g] = oe_b;
      end
   endgenerate

   // outputs registered; all undriven during reset and strap window
   always @(posedge clk_sys_in) begin
      if (!rst_n_in || !strap_done) begin
         first_host_indicator_pins_out <= 4'h0;
         first_host_indicator_pins_oe_out <= 4'h0;
         second_host_indicator_pins_out <= 4'h0;
         second_host_indicator_pins_oe_out <= 4'h0;
      end else begin
         first_host_indicator_pins_out <= next_a;
         first_host_indicator_pins_oe_out <= next_a_oe;
         second_host_indicator_pins_out <= next_b;
         second_host_indicator_pins_oe_out <= next_b_oe;
      end
   end

   // strap level always passed to config logic; strap_valid_out set only under internal defaults
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         strap_out <= 4'h0;
         strap_valid_out <= 1'b0;
      end else begin
         strap_out <= strap;
         strap_valid_out <= strap_done && internal_default_in;
      end
   end
endmodule

// >>> tb/pli_chk.sv
// concurrent checks on the port indicator block ports
module pli_chk (
   input logic clk_sys_in,
   input logic rst_n_in,
   input logic [1:0] mode_in,
   input logic internal_default_in,
   input logic hub_suspend_in,
   input logic [3:0] port_enable_in,
   input logic [7:0] port_owner_in,
   input logic [3:0] port_attached_in,
   input logic [3:0] port_high_speed_in,
   input logic [3:0] usb_green_in,
   input logic [3:0] first_host_indicator_pins_out,
   input logic [3:0] first_host_indicator_pins_oe_out,
   input logic [3:0] second_host_indicator_pins_oe_out,
   input logic [3:0] strap_out,
   input logic strap_valid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   logic [16:0] wc;
   wire live = cnt == 4'h8;
   wire wact = live && mode_in == 2'h2 && first_host_indicator_pins_oe_out[0]
      && !port_attached_in[0] && !hub_suspend_in;
   // owned-by-host mask per port
   function automatic [3:0] own(input [7:0] o, input [1:0] c);
      for (int i = 0; i < 4; i++)
         own[i] = o[2*i+:2] == c;
   endfunction
   // live waits out strap capture; wc measures how long the wave pin stands
   always @(posedge clk_sys_in) begin
      cnt <= !rst_n_in ? 4'h0 : cnt + {3'h0, cnt != 4'h8};
      wc <= (!wact || $changed(first_host_indicator_pins_out[0])) ? 17'h0 : wc + 17'h1;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   chk_reset_off: assert property (disable iff (1'b0) !rst_n_in |=>
      {first_host_indicator_pins_oe_out, second_host_indicator_pins_oe_out} == 8'h00)
      else $error("pins driven in reset");
   chk_mode_off: assert property (mode_in == 2'h3 |=>
      {first_host_indicator_pins_oe_out, second_host_indicator_pins_oe_out} == 8'h00)
      else $error("pins driven in off mode");
   chk_usb_green: assert property (live && mode_in == 2'h0 |=>
      first_host_indicator_pins_out == ($past(usb_green_in) ^ strap_out))
      else $error("green pin wrong");
   chk_basic_own: assert property (live && mode_in == 2'h1 |=>
      first_host_indicator_pins_out == (own($past(port_owner_in), 2'h1)
      & $past(port_enable_in) ^ strap_out)) else $error("owner pin wrong");
   chk_speed_oe: assert property (live && mode_in == 2'h2 |=>
      second_host_indicator_pins_oe_out == (own($past(port_owner_in), 2'h2)
      & $past(port_enable_in) & ($past(port_attached_in) | {4{!$past(hub_suspend_in)}})))
      else $error("drive enable wrong");
   chk_speed_lvl: assert property (live && mode_in == 2'h2 |=>
      ((first_host_indicator_pins_out ^ $past(port_high_speed_in))
      & first_host_indicator_pins_oe_out & $past(port_attached_in)) == 4'h0)
      else $error("speed level wrong");
   chk_wave_half: assert property (wact |-> wc <= 17'hC350)
      else $error("wave half too long");
   chk_strap_hold: assert property (live && $past(live) |-> $stable(strap_out))
      else $error("strap changed");
   chk_valid_gate: assert property (strap_valid_out |-> $past(internal_default_in))
      else $error("strap valid without default");
endmodule
bind pli_port_led_indicator pli_chk u_chk (.*);

// >>> tb/pli_led_model.sv
// led circuit model: strap resistors on the first pins, read back at the pad
module pli_led_model #(parameter logic [3:0] STRAP = 4'h5) (
   input logic [3:0] pin_out,
   input logic [3:0] pin_oe,
   output logic [3:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // an undriven pin settles to its strap resistor level
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & STRAP);
endmodule

// >>> tb/pli_port_led_indicator_tb.sv
// testbench for the port indicator block
module pli_port_led_indicator_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [1:0] m;
      logic [3:0] e;
      logic [7:0] o;
      logic [3:0] t, h, g, k, xa, xb, xao, xbo;
   } pli_row_t;
   pli_row_t rows [6] = '{
      '{2'h0, 4'hF, 8'h55, 4'h0, 4'h0, 4'hA, 4'h6, 4'hF, 4'h3, 4'hF, 4'hF},
      '{2'h1, 4'hF, 8'h8D, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'hD, 4'hF, 4'hF},
      '{2'h1, 4'hE, 8'h55, 4'h0, 4'h0, 4'h0, 4'h0, 4'hB, 4'h5, 4'hF, 4'hF},
      '{2'h2, 4'hF, 8'h5A, 4'hF, 4'h5, 4'h0, 4'h0, 4'h4, 4'h1, 4'hC, 4'h3},
      '{2'h3, 4'hF, 8'h55, 4'hF, 4'h5, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0},
      '{2'h2, 4'hB, 8'hC6, 4'h3, 4'h2, 4'h0, 4'h0, 4'h2, 4'h0, 4'h2, 4'h1}};
   pli_row_t r;
   logic clk_sys_in = 0, rst_n_in = 0, idef = 1, susp = 0, valid;
   logic [3:0] pins, a, aoe, b, boe, strap;
   int err_count = 0, cmp_count = 0, n;
   // strap resistors hold the first pins at 4'h5 while undriven
   pli_led_model #(.STRAP(4'h5)) u_led (.pin_out(a), .pin_oe(aoe), .pin_level(pins));
   pli_port_led_indicator dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .mode_in(r.m), .internal_default_in(idef), .hub_suspend_in(susp),
      .port_enable_in(r.e), .port_owner_in(r.o), .port_attached_in(r.t),
      .port_high_speed_in(r.h), .usb_green_in(r.g), .usb_amber_in(r.k),
      .first_host_indicator_pins_in(pins), .first_host_indicator_pins_out(a),
      .first_host_indicator_pins_oe_out(aoe), .second_host_indicator_pins_out(b),
      .second_host_indicator_pins_oe_out(boe), .strap_out(strap), .strap_valid_out(valid));
   always #5 clk_sys_in = ~clk_sys_in;
   task chk(input logic [16:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // inputs change 1 ns after the edge so no race with the sampling edge
   task step(input int k);
      repeat (k) @(posedge clk_sys_in);
      #1;
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      r = rows[4];
      step(6);
      chk(aoe | boe, 0);
      rst_n_in = 1;
      step(10);
      chk(strap, 4'h5);
      chk(valid, 1);
      $display("reset test done");
      foreach (rows[i]) begin
         r = rows[i];
         step(2);
         chk(aoe, r.xao);
         chk(boe, r.xbo);
         chk(a & aoe, r.xa);
         chk(b & boe, r.xb);
         $display("row %0d done", i);
      end
      // suspend: attached ports keep speed level, unattached go dark
      r = rows[3];
      r.t = 4'h5;
      susp = 1;
      step(2);
      chk({aoe, boe}, 8'h41);
      chk({a & aoe, b & boe}, 8'h41);
      r.m = 2'h1;
      step(2);
      chk({a, b}, 8'h96);
      $display("suspend test done");
      // wave: measure one full half period on port 1 pin A
      susp = 0;
      r = rows[3];
      r.o = 8'h01;
      r.t = 4'h0;
      step(2);
      for (n = 0; n < 60000 && a[0] !== 1'b1; n++)
         step(1);
      if (n == 60000) err_count++;
      for (n = 0; n < 60000 && a[0] !== 1'b0; n++)
         step(1);
      if (n == 60000) err_count++;
      chk(n[16:0], 17'hC350);
      $display("wave test done");
      // second reset without internal defaults: straps not valid
      rst_n_in = 0;
      idef = 0;
      step(6);
      chk(aoe | boe, 0);
      rst_n_in = 1;
      step(10);
      chk(valid, 0);
      chk(strap, 4'h5);
      $display("strap test done");
      end_of_test;
   end
endmodule
